/* File: logic/pco_pkg.sv */
// Package: register map, field positions and reset values of the cutoff control bank
package pco_pkg;
	localparam int PCO_AW = 6;
	localparam int PCO_DW = 32;
	typedef logic [7:0] pco_reg_t;
	// Register byte addresses (one aligned word each)
	localparam logic [PCO_AW-1:0] PCO_OFF_CLKGATE = 6'h00;
	localparam logic [PCO_AW-1:0] PCO_OFF_OPMODE  = 6'h04;
	localparam logic [PCO_AW-1:0] PCO_OFF_CMPMODE = 6'h08;
	localparam logic [PCO_AW-1:0] PCO_OFF_CMPOUT  = 6'h0C;
	localparam logic [PCO_AW-1:0] PCO_OFF_MASKLO  = 6'h10;
	localparam logic [PCO_AW-1:0] PCO_OFF_FLAGLO  = 6'h14;
	localparam logic [PCO_AW-1:0] PCO_OFF_MASKHI  = 6'h18;
	localparam logic [PCO_AW-1:0] PCO_OFF_FLAGHI  = 6'h1C;
	localparam logic [PCO_AW-1:0] PCO_OFF_GAINCTL = 6'h20;
	localparam logic [PCO_AW-1:0] PCO_OFF_TSTAT0  = 6'h24;
	localparam logic [PCO_AW-1:0] PCO_OFF_TSTART  = 6'h28;
	localparam logic [PCO_AW-1:0] PCO_OFF_EDGECFG = 6'h2C;
	// Field positions
	localparam int PCO_B_CLKEN   = 6;
	localparam int PCO_B_DETMODE = 1;
	localparam int PCO_B_C0EN    = 0;
	localparam int PCO_B_C0MON   = 3;
	localparam int PCO_B_C1EN    = 4;
	localparam int PCO_B_C1MON   = 7;
	localparam int PCO_B_COMPARATOR_0_OUTPUT_ENABLE    = 1;
	localparam int PCO_B_COMPARATOR_1_OUTPUT_ENABLE    = 5;
	localparam int PCO_B_C0MK    = 7;
	localparam int PCO_B_C0IF    = 7;
	localparam int PCO_B_C1MK    = 0;
	localparam int PCO_B_C1IF    = 0;
	localparam int PCO_B_T0MK    = 1;
	localparam int PCO_B_T0IF    = 1;
	localparam int PCO_B_GAINEN  = 7;
	localparam int PCO_B_MATCHA  = 0;
	localparam int PCO_B_RUN0    = 0;
	localparam int PCO_B_RUN1    = 1;
	localparam int PCO_B_COMPARATOR_1_EDGE_MODE   = 7;
	localparam int PCO_B_COMPARATOR_1_EDGE_POLARITY   = 6;
	// Writable bit masks and reset values
	localparam pco_reg_t PCO_WM_CLKGATE = 8'h40;
	localparam pco_reg_t PCO_WM_OPMODE  = 8'h02;
	localparam pco_reg_t PCO_WM_CMPMODE = 8'h11;
	localparam pco_reg_t PCO_WM_CMPOUT  = 8'h22;
	localparam pco_reg_t PCO_WM_MASKLO  = 8'h80;
	localparam pco_reg_t PCO_WM_MASKHI  = 8'h03;
	localparam pco_reg_t PCO_WM_GAINCTL = 8'h80;
	localparam pco_reg_t PCO_WM_TSTART  = 8'h03;
	localparam pco_reg_t PCO_WM_EDGECFG = 8'hC0;
	localparam pco_reg_t PCO_RST_ZERO   = 8'h00;
	localparam pco_reg_t PCO_RST_MASKLO = 8'h7F;
	localparam pco_reg_t PCO_RST_MASKHI = 8'hFC;
	localparam pco_reg_t PCO_RST_MASKLV = 8'h80;
	localparam pco_reg_t PCO_RST_MASKHV = 8'h03;
	localparam logic [1:0] PCO_HTRANS_NONSEQ = 2'b10;
	localparam logic [2:0] PCO_HSIZE_WORD    = 3'b010;
	localparam int PCO_CNT_W = 16;
endpackage : pco_pkg

/* File: logic/pco_cutoff_ctrl.sv */
// Cutoff control register bank with AHB-Lite slave, comparators gating and timers
// What this block does
// - Option unit clock enable passes clock only while gate bit 6 is one.
// - Detection mode bit selects two-stage (0) or overcurrent/induced (1) detection.
// - Comparator 0 works only while comparator mode bit 0 is one.
// - Comparator 1 works only while comparator mode bit 4 is one.
// - Comparator 0 cutoff output low unless its output enable is set.
// - Comparator 1 cutoff output low unless its output enable is set.
// - Mask bit one blocks its source; positions bit 7, bit 0, bit 1.
// - Sources set their request flags; software writes zero to clear them.
// - Gain amplifier runs only while amplifier enable bit 7 is one.
// - Capture input edge sets match flag A; cleared by read then write zero.
// - Channel 0 and 1 counters run while start bits 0 and 1 are one.
// - Comparator 1 single-edge: rising edge when polarity zero, falling when one.
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
module pco_cutoff_ctrl
#(
	parameter int CNT_W = pco_pkg::PCO_CNT_W
)
(
	input  wire logic                       mclk,
	input  wire logic                       rstn,
	input  wire logic                       hsel,
	input  wire logic [pco_pkg::PCO_AW-1:0] haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [pco_pkg::PCO_DW-1:0] hwdata,
	input  wire logic                       hready,
	output logic [pco_pkg::PCO_DW-1:0]      hrdata,
	output logic                            hreadyout,
	output logic                            hresp,
	input  wire logic                       cmp0Result,
	input  wire logic                       cmp1Result,
	input  wire logic                       captureInputA,
	input  wire logic                       timerCh0Event,
	input  wire logic [5:0]                 pwmIn,
	output logic [5:0]                      pwmOut,
	output logic [5:0]                      pwmOutEn,
	output logic                            optionUnitClockEnable,
	output logic                            detectionModeSelect,
	output logic                            comparator0Enable,
	output logic                            comparator1Enable,
	output logic                            gainAmpEnable,
	output logic                            comparator0CutoffOutput,
	output logic                            comparator1CutoffOutput,
	output logic [CNT_W-1:0]                channel0Count,
	output logic [CNT_W-1:0]                channel1Count,
	output logic                            irq
);
	import pco_pkg::*;

	pco_reg_t clkGate, opMode, cmpMode, cmpOut, maskLo, maskHi;
	pco_reg_t gainCtl, tStart, edgeCfg;
	pco_reg_t next_clkGate, next_opMode, next_cmpMode, next_cmpOut;
	pco_reg_t next_maskLo, next_maskHi, next_gainCtl, next_tStart;
	pco_reg_t next_edgeCfg;
	logic c0Flag, c1Flag, t0Flag, matchA, matchArmed;
	logic next_c0Flag, next_c1Flag, next_t0Flag, next_matchA;
	logic next_matchArmed;
	logic wrPend, next_wrPend;
	logic [PCO_AW-1:0] wrAddr, next_wrAddr;
	logic [PCO_DW-1:0] next_hrdata;
	logic c0Prev, c1Prev, capPrev, next_c0Prev, next_c1Prev, next_capPrev;
	logic [CNT_W-1:0] next_ch0, next_ch1;
	logic c0Edge, c1Edge, capEdge, cutoff;
	logic addrValid, rdAccess;
	pco_reg_t rdByte;
	pco_reg_t wb;

	// Address phase qualifier; single-cycle zero-wait answer
	assign addrValid = hsel && hready && (htrans == PCO_HTRANS_NONSEQ);
	assign rdAccess  = addrValid && !hwrite;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign wb        = hwdata[7:0];

	// Comparator edges, only while the comparator is running
	assign c0Edge = cmpMode[PCO_B_C0EN] && cmp0Result && !c0Prev;
	always_comb
	begin
		c1Edge = 1'b0;
		if (cmpMode[PCO_B_C1EN])
		begin
			if (edgeCfg[PCO_B_COMPARATOR_1_EDGE_MODE])
				c1Edge = cmp1Result != c1Prev;
			else if (edgeCfg[PCO_B_COMPARATOR_1_EDGE_POLARITY])
				c1Edge = !cmp1Result && c1Prev;
			else
				c1Edge = cmp1Result && !c1Prev;
		end
	end
	assign capEdge = captureInputA && !capPrev;

	// Control outputs straight from register bits
	assign optionUnitClockEnable = clkGate[PCO_B_CLKEN];
	assign detectionModeSelect   = opMode[PCO_B_DETMODE];
	assign comparator0Enable     = cmpMode[PCO_B_C0EN];
	assign comparator1Enable     = cmpMode[PCO_B_C1EN];
	assign gainAmpEnable         = gainCtl[PCO_B_GAINEN];
	// Cutoff outputs held low unless enabled; comparator off reads as inactive
	assign comparator0CutoffOutput = cmpOut[PCO_B_COMPARATOR_0_OUTPUT_ENABLE] &&
		cmpMode[PCO_B_C0EN] && cmp0Result;
	assign comparator1CutoffOutput = cmpOut[PCO_B_COMPARATOR_1_OUTPUT_ENABLE] &&
		cmpMode[PCO_B_C1EN] && cmp1Result;
	// Cutoff drops the drivers at once so the bridge never waits a cycle
	assign cutoff   = comparator0CutoffOutput || comparator1CutoffOutput;
	assign pwmOut   = pwmIn;
	assign pwmOutEn = cutoff ? 6'h00 : 6'h3F;
	// Masked flags never reach the interrupt line
	assign irq = (c0Flag && !maskLo[PCO_B_C0MK]) ||
		(c1Flag && !maskHi[PCO_B_C1MK]) ||
		(t0Flag && !maskHi[PCO_B_T0MK]);

	// Read mux
	always_comb
	begin
		rdByte = PCO_RST_ZERO;
		case (haddr)
			PCO_OFF_CLKGATE: rdByte = clkGate;
			PCO_OFF_OPMODE:  rdByte = opMode;
			PCO_OFF_CMPMODE: rdByte = cmpMode
				| (8'(cmp1Result && cmpMode[PCO_B_C1EN]) << PCO_B_C1MON)
				| (8'(cmp0Result && cmpMode[PCO_B_C0EN]) << PCO_B_C0MON);
			PCO_OFF_CMPOUT:  rdByte = cmpOut;
			PCO_OFF_MASKLO:  rdByte = maskLo | PCO_RST_MASKLO;
			PCO_OFF_FLAGLO:  rdByte = 8'(c0Flag) << PCO_B_C0IF;
			PCO_OFF_MASKHI:  rdByte = maskHi | PCO_RST_MASKHI;
			PCO_OFF_FLAGHI:  rdByte = (8'(t0Flag) << PCO_B_T0IF)
				| (8'(c1Flag) << PCO_B_C1IF);
			PCO_OFF_GAINCTL: rdByte = gainCtl;
			PCO_OFF_TSTAT0:  rdByte = 8'(matchA) << PCO_B_MATCHA;
			PCO_OFF_TSTART:  rdByte = tStart;
			PCO_OFF_EDGECFG: rdByte = edgeCfg;
			default:         rdByte = PCO_RST_ZERO;
		endcase
	end

	// Next state of registers, flags and counters
	always_comb
	begin
		next_clkGate = clkGate;
		next_opMode  = opMode;
		next_cmpMode = cmpMode;
		next_cmpOut  = cmpOut;
		next_maskLo  = maskLo;
		next_maskHi  = maskHi;
		next_gainCtl = gainCtl;
		next_tStart  = tStart;
		next_edgeCfg = edgeCfg;
		next_c0Flag  = c0Flag;
		next_c1Flag  = c1Flag;
		next_t0Flag  = t0Flag;
		next_matchA  = matchA;
		next_matchArmed = matchArmed;
		next_wrPend  = addrValid && hwrite;
		next_wrAddr  = addrValid ? haddr : wrAddr;
		next_hrdata  = rdAccess ? {24'h000000, rdByte} : hrdata;
		next_c0Prev  = cmp0Result;
		next_c1Prev  = cmp1Result;
		next_capPrev = captureInputA;
		next_ch0 = channel0Count;
		next_ch1 = channel1Count;
		// A read that sees match flag A set arms its clear
		if (rdAccess && haddr == PCO_OFF_TSTAT0 && matchA)
			next_matchArmed = 1'b1;
		// Data phase of a write
		if (wrPend)
		begin
			case (wrAddr)
				PCO_OFF_CLKGATE: next_clkGate = wb & PCO_WM_CLKGATE;
				PCO_OFF_OPMODE:  next_opMode  = wb & PCO_WM_OPMODE;
				PCO_OFF_CMPMODE: next_cmpMode = wb & PCO_WM_CMPMODE;
				PCO_OFF_CMPOUT:  next_cmpOut  = wb & PCO_WM_CMPOUT;
				PCO_OFF_MASKLO:  next_maskLo  = wb & PCO_WM_MASKLO;
				PCO_OFF_MASKHI:  next_maskHi  = wb & PCO_WM_MASKHI;
				PCO_OFF_GAINCTL: next_gainCtl = wb & PCO_WM_GAINCTL;
				PCO_OFF_TSTART:  next_tStart  = wb & PCO_WM_TSTART;
				PCO_OFF_EDGECFG: next_edgeCfg = wb & PCO_WM_EDGECFG;
				PCO_OFF_FLAGLO:
					if (!wb[PCO_B_C0IF])
						next_c0Flag = 1'b0;
				PCO_OFF_FLAGHI:
				begin
					if (!wb[PCO_B_C1IF])
						next_c1Flag = 1'b0;
					if (!wb[PCO_B_T0IF])
						next_t0Flag = 1'b0;
				end
				PCO_OFF_TSTAT0:
					if (!wb[PCO_B_MATCHA] && matchArmed)
					begin
						next_matchA = 1'b0;
						next_matchArmed = 1'b0;
					end
				default: ;
			endcase
		end
		// Events set after the clear so a set in the same cycle wins
		if (c0Edge)
			next_c0Flag = 1'b1;
		if (c1Edge)
			next_c1Flag = 1'b1;
		if (timerCh0Event)
			next_t0Flag = 1'b1;
		if (capEdge)
			next_matchA = 1'b1;
		// Counters advance only while their start bits are set
		if (tStart[PCO_B_RUN0])
			next_ch0 = channel0Count + 1'b1;
		if (tStart[PCO_B_RUN1])
			next_ch1 = channel1Count + 1'b1;
	end

	// State registers
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			clkGate <= PCO_RST_ZERO;
			opMode  <= PCO_RST_ZERO;
			cmpMode <= PCO_RST_ZERO;
			cmpOut  <= PCO_RST_ZERO;
			maskLo  <= PCO_RST_MASKLV;
			maskHi  <= PCO_RST_MASKHV;
			gainCtl <= PCO_RST_ZERO;
			tStart  <= PCO_RST_ZERO;
			edgeCfg <= PCO_RST_ZERO;
			c0Flag  <= 1'b0;
			c1Flag  <= 1'b0;
			t0Flag  <= 1'b0;
			matchA  <= 1'b0;
			matchArmed <= 1'b0;
			wrPend  <= 1'b0;
			wrAddr  <= '0;
			hrdata  <= '0;
			c0Prev  <= 1'b0;
			c1Prev  <= 1'b0;
			capPrev <= 1'b0;
			channel0Count <= '0;
			channel1Count <= '0;
		end
		else
		begin
			clkGate <= next_clkGate;
			opMode  <= next_opMode;
			cmpMode <= next_cmpMode;
			cmpOut  <= next_cmpOut;
			maskLo  <= next_maskLo;
			maskHi  <= next_maskHi;
			gainCtl <= next_gainCtl;
			tStart  <= next_tStart;
			edgeCfg <= next_edgeCfg;
			c0Flag  <= next_c0Flag;
			c1Flag  <= next_c1Flag;
			t0Flag  <= next_t0Flag;
			matchA  <= next_matchA;
			matchArmed <= next_matchArmed;
			wrPend  <= next_wrPend;
			wrAddr  <= next_wrAddr;
			hrdata  <= next_hrdata;
			c0Prev  <= next_c0Prev;
			c1Prev  <= next_c1Prev;
			capPrev <= next_capPrev;
			channel0Count <= next_ch0;
			channel1Count <= next_ch1;
		end
	end

	// Register levels: a write lands on the edge after its data phase
	chk_clock_gate: assert property (@(posedge mclk)
		disable iff (!rstn)
		(wrPend && wrAddr == PCO_OFF_CLKGATE) |=>
		optionUnitClockEnable == $past(hwdata[PCO_B_CLKEN]))
		else $error("option clock gate not written");
	chk_mode_sel: assert property (@(posedge mclk)
		disable iff (!rstn)
		(wrPend && wrAddr == PCO_OFF_OPMODE) |=>
		detectionModeSelect == $past(hwdata[PCO_B_DETMODE]))
		else $error("detection mode not written");
	chk_gain_en: assert property (@(posedge mclk)
		disable iff (!rstn)
		(wrPend && wrAddr == PCO_OFF_GAINCTL) |=>
		gainAmpEnable == $past(hwdata[PCO_B_GAINEN]))
		else $error("gain enable not written");
	// Cutoff path: held low unless enabled, follows the result once enabled
	chk_cut0_low: assert property (@(posedge mclk)
		disable iff (!rstn)
		!cmpOut[PCO_B_COMPARATOR_0_OUTPUT_ENABLE] |-> !comparator0CutoffOutput)
		else $error("cutoff 0 not held low");
	chk_cut0_follow: assert property (@(posedge mclk)
		disable iff (!rstn)
		(cmpOut[PCO_B_COMPARATOR_0_OUTPUT_ENABLE] && cmpMode[PCO_B_C0EN]) |->
		comparator0CutoffOutput == cmp0Result)
		else $error("cutoff 0 does not follow comparator");
	chk_cut1_low: assert property (@(posedge mclk)
		disable iff (!rstn)
		!cmpOut[PCO_B_COMPARATOR_1_OUTPUT_ENABLE] |-> !comparator1CutoffOutput)
		else $error("cutoff 1 not held low");
	chk_cut1_follow: assert property (@(posedge mclk)
		disable iff (!rstn)
		(cmpOut[PCO_B_COMPARATOR_1_OUTPUT_ENABLE] && cmpMode[PCO_B_C1EN]) |->
		comparator1CutoffOutput == cmp1Result)
		else $error("cutoff 1 does not follow comparator");
	chk_pwm_hiz: assert property (@(posedge mclk)
		disable iff (!rstn)
		(comparator0CutoffOutput || comparator1CutoffOutput) |->
		pwmOutEn == 6'h00)
		else $error("pwm driven during cutoff");
	chk_pwm_drive: assert property (@(posedge mclk)
		disable iff (!rstn)
		!(comparator0CutoffOutput || comparator1CutoffOutput) |->
		pwmOutEn == 6'h3F)
		else $error("pwm not driven without cutoff");
	// Flags: a source sets its flag, a zero write clears it, a set wins
	chk_c0_flag_set: assert property (@(posedge mclk)
		disable iff (!rstn)
		($past(rstn) && cmpMode[PCO_B_C0EN] && $rose(cmp0Result)) |=>
		c0Flag)
		else $error("comparator 0 flag not set");
	chk_t0_flag_set: assert property (@(posedge mclk)
		disable iff (!rstn)
		timerCh0Event |=> t0Flag)
		else $error("timer channel 0 flag not set");
	chk_flag_clear: assert property (@(posedge mclk)
		disable iff (!rstn)
		(wrPend && wrAddr == PCO_OFF_FLAGLO && !hwdata[PCO_B_C0IF] &&
		!$rose(cmp0Result)) |=> !c0Flag)
		else $error("comparator 0 flag not cleared by zero");
	chk_c0_enable: assert property (@(posedge mclk)
		disable iff (!rstn)
		!comparator0Enable |=> !c0Flag || $past(c0Flag))
		else $error("disabled comparator 0 set flag");
	chk_c1_off: assert property (@(posedge mclk)
		disable iff (!rstn)
		(!cmpMode[PCO_B_C1EN] && !c1Flag && !wrPend) |=> !c1Flag)
		else $error("disabled comparator 1 set flag");
	chk_c1_rise: assert property (@(posedge mclk)
		disable iff (!rstn)
		(cmpMode[PCO_B_C1EN] && !edgeCfg[PCO_B_COMPARATOR_1_EDGE_MODE] &&
		!edgeCfg[PCO_B_COMPARATOR_1_EDGE_POLARITY] && $rose(cmp1Result)) |=> c1Flag)
		else $error("comparator 1 rising edge missed");
	chk_c1_fall: assert property (@(posedge mclk)
		disable iff (!rstn)
		($past(rstn) && cmpMode[PCO_B_C1EN] &&
		!edgeCfg[PCO_B_COMPARATOR_1_EDGE_MODE] && edgeCfg[PCO_B_COMPARATOR_1_EDGE_POLARITY] &&
		$fell(cmp1Result)) |=> c1Flag)
		else $error("comparator 1 falling edge missed");
	chk_match_set: assert property (@(posedge mclk)
		disable iff (!rstn)
		$rose(captureInputA) |-> ##1 matchA)
		else $error("match flag A not set");
	chk_match_keep: assert property (@(posedge mclk)
		disable iff (!rstn)
		(matchA && !matchArmed) |=> matchA)
		else $error("match flag A cleared without a read");
	// Interrupt line and channel counters
	chk_irq_mask: assert property (@(posedge mclk)
		disable iff (!rstn)
		(maskLo[PCO_B_C0MK] && maskHi[PCO_B_C1MK] && maskHi[PCO_B_T0MK])
		|-> !irq)
		else $error("masked interrupt asserted");
	chk_irq_pass: assert property (@(posedge mclk)
		disable iff (!rstn)
		(c0Flag && !maskLo[PCO_B_C0MK]) |-> irq)
		else $error("unmasked comparator 0 flag lost");
	chk_count_hold: assert property (@(posedge mclk)
		disable iff (!rstn)
		!tStart[PCO_B_RUN0] |=> $stable(channel0Count))
		else $error("channel 0 counted while stopped");
	chk_count_run: assert property (@(posedge mclk)
		disable iff (!rstn)
		tStart[PCO_B_RUN1] |=>
		channel1Count == $past(channel1Count) + 1'b1)
		else $error("channel 1 did not count");
	// Main scenarios
	cov_cutoff: cover property (@(posedge mclk) $rose(pwmOutEn == 6'h00));
	cov_irq: cover property (@(posedge mclk) $rose(irq));
	cov_match_clear: cover property (@(posedge mclk) $fell(matchA));
	cov_both_run: cover property (@(posedge mclk) tStart == PCO_WM_TSTART);
	cov_c1_clear: cover property (@(posedge mclk) $fell(c1Flag));
endmodule : pco_cutoff_ctrl

/* File: verification/pco_cutoff_ctrl_bench.sv */
// Self-checking bench for the cutoff control register bank
`timescale 1ns/10ps
module pco_cutoff_ctrl_bench;
	import pco_pkg::*;
	localparam int CW = 8;
	logic              mclk, rstn, hsel, hwrite, hresp, hreadyout;
	logic [PCO_AW-1:0] haddr;
	logic [1:0]        htrans;
	logic [2:0]        hsize;
	logic [31:0]       hwdata, hrdata;
	logic              c0, c1, capA, tEv, clkEn, detMode, en0, en1;
	logic              gainEn, cut0, cut1, irq;
	logic [5:0]        pwmIn, pwmOut, pwmOutEn;
	logic [CW-1:0]     cnt0, cnt1, a0, a1;
	int                errorCnt, nChecks, cyc, ri, armA;
	int wm[13] = '{8'h40, 8'h02, 8'h11, 8'h22, 8'h80, 0, 8'h03, 0, 8'h80, 0,
		8'h03, 8'hC0, 0};
	int ones[13] = '{0, 0, 0, 0, 8'h7F, 0, 8'hFC, 0, 0, 0, 0, 0, 0};
	// Model of every register; masks come out of reset all blocked
	int mdl[13] = '{0, 0, 0, 0, 8'hFF, 0, 8'hFF, 0, 0, 0, 0, 0, 0};

	pco_cutoff_ctrl #(.CNT_W(CW)) dut
	(
		.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .cmp0Result(c0), .cmp1Result(c1),
		.captureInputA(capA), .timerCh0Event(tEv), .pwmIn(pwmIn),
		.pwmOut(pwmOut), .pwmOutEn(pwmOutEn), .optionUnitClockEnable(clkEn),
		.detectionModeSelect(detMode), .comparator0Enable(en0),
		.comparator1Enable(en1), .gainAmpEnable(gainEn),
		.comparator0CutoffOutput(cut0), .comparator1CutoffOutput(cut1),
		.channel0Count(cnt0), .channel1Count(cnt1), .irq(irq)
	);

	// Free-running 100 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errorCnt++;
			giveVerdict();
		end
	end

	task automatic giveVerdict;
		if (errorCnt == 0 && nChecks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : giveVerdict

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		nChecks++;
		if (g !== e)
		begin
			errorCnt++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	// One single transfer; entered just after a rising edge
	task automatic bus(input logic w, input int i, input logic [31:0] wd,
		output logic [31:0] rdat);
		hsel <= 1'b1;
		haddr <= PCO_AW'(i * 4);
		hwrite <= w;
		htrans <= PCO_HTRANS_NONSEQ;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rdat = hrdata;
		chk("hresp", 32'h0, hresp);
	endtask : bus

	// Flags clear only on zero; match flag A needs a read that saw it set
	task automatic wr(input int i, input logic [31:0] v);
		logic [31:0] d;
		bus(1'b1, i, v, d);
		if (i == 5 || i == 7 || (i == 9 && armA != 0))
			mdl[i] = mdl[i] & v;
		else if (i != 9)
			mdl[i] = (v & wm[i]) | ones[i];
		// A write of one leaves an armed clear pending
		if (i == 9 && !v[0])
			armA = 0;
	endtask : wr

	task automatic rd(input int i);
		logic [31:0] d;
		logic [31:0] e;
		bus(1'b0, i, 32'h0, d);
		e = mdl[i];
		if (i == 2)
			e = e | ((mdl[2][4] & c1) << 7) | ((mdl[2][0] & c0) << 3);
		if (i == 9 && e[0])
			armA = 1;
		chk($sformatf("reg %0d", i), e, d);
	endtask : rd

	// Comparator results move; gated edges update the model flags
	task automatic setcmp(input logic n0, input logic n1);
		logic o0, o1, g0, g1;
		o0 = c0 & mdl[2][0];
		o1 = c1 & mdl[2][4];
		g0 = n0 & mdl[2][0];
		g1 = n1 & mdl[2][4];
		c0 <= n0;
		c1 <= n1;
		pwmIn <= 6'($urandom);
		if (!o0 && g0)
			mdl[5] |= 8'h80;
		if (o1 != g1 && (mdl[11][7] || g1 == !mdl[11][6]))
			mdl[7] |= 1;
		repeat (2) @(posedge mclk);
	endtask : setcmp

	// Level outputs are looked at mid-cycle, once everything has settled
	task automatic outs;
		logic g0, g1;
		@(negedge mclk);
		g0 = mdl[3][1] & mdl[2][0] & c0;
		g1 = mdl[3][5] & mdl[2][4] & c1;
		chk("clock enable", mdl[0][6], clkEn);
		chk("detect mode", mdl[1][1], detMode);
		chk("cmp0 enable", mdl[2][0], en0);
		chk("cmp1 enable", mdl[2][4], en1);
		chk("gain enable", mdl[8][7], gainEn);
		chk("cutoff0", g0, cut0);
		chk("cutoff1", g1, cut1);
		chk("pwm enable", (g0 | g1) ? 6'h00 : 6'h3F, pwmOutEn);
		chk("pwm out", pwmIn, pwmOut);
		chk("irq", ((mdl[5] & ~mdl[4] & 8'h80) |
			(mdl[7] & ~mdl[6] & 3)) != 0, irq);
		@(posedge mclk);
	endtask : outs

	// Main sequence
	initial
	begin
		{rstn, hsel, hwrite, c0, c1, capA, tEv} <= 7'h00;
		{haddr, htrans, hwdata, pwmIn} <= '0;
		hsize <= PCO_HSIZE_WORD;
		void'($urandom(32'hB3D5));
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 13; i++)
			rd(i);
		outs;
		// A blind clear must not lose a pending capture
		capA <= 1'b1;
		mdl[9] |= 1;
		@(posedge mclk);
		capA <= 1'b0;
		@(posedge mclk);
		wr(9, 0);
		rd(9);
		wr(9, 0);
		rd(9);
		// Every register once with all ones, then with all zeros
		for (int k = 0; k < 26; k++)
		begin
			wr(k % 13, (k < 13) ? 32'hFFFF_FFFF : 32'h0);
			rd(k % 13);
			outs;
		end
		// Random traffic, an unmapped word among it, comparators quiet
		repeat (24)
		begin
			ri = $urandom_range(12);
			wr(ri, $urandom);
			rd(ri);
			outs;
		end
		wr(2, 8'h11);
		wr(3, 8'h22);
		wr(5, 0);
		wr(7, 0);
		repeat (40)
		begin
			setcmp(1'($urandom), 1'($urandom));
			if ($urandom_range(3) == 0)
			begin
				tEv <= 1'b1;
				mdl[7] |= 2;
				@(posedge mclk);
				tEv <= 1'b0;
			end
			outs;
			rd(5);
			rd(7);
			case ($urandom_range(3))
				0: wr(4, $urandom);
				1: wr(6, $urandom);
				2: wr(11, $urandom);
				default: wr($urandom_range(1) ? 5 : 7, 0);
			endcase
		end
		// Disabled comparators ignore their results
		setcmp(1'b0, 1'b0);
		wr(2, 0);
		setcmp(1'b1, 1'b1);
		outs;
		rd(2);
		rd(5);
		rd(7);
		// Every run combination of the two channel counters
		for (int m = 0; m < 4; m++)
		begin
			wr(10, m);
			@(negedge mclk);
			a0 = cnt0;
			a1 = cnt1;
			repeat (5) @(negedge mclk);
			chk("count0", m[0] ? 5 : 0, CW'(cnt0 - a0));
			chk("count1", m[1] ? 5 : 0, CW'(cnt1 - a1));
			@(posedge mclk);
		end
		giveVerdict();
	end
endmodule : pco_cutoff_ctrl_bench
